// ### load_store_replay_prefetch.sv
// memory-operation control: prefetch flavours, miss tracking, forwarding, replay traps
`timescale 1ns/1ps
`default_nettype none
module load_store_replay_prefetch import lsrp_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic late_variant,
  input wire logic iss_valid,
  input wire logic [3:0] iss_op,
  input wire logic [ADDR_W-1:0] iss_addr,
  input wire logic iss_addr_bad,
  input wire logic [SEQ_W-1:0] iss_seq,
  input wire logic [WT_IDX_W-1:0] iss_pc_idx,
  input wire logic [DATA_W-1:0] iss_data,
  output logic iss_ready_r,
  input wire logic cache_hit,
  input wire logic cache_hit_owned,
  input wire logic [DATA_W-1:0] cache_rdata,
  output logic cache_req_valid_r,
  output logic [ADDR_W-1:0] cache_req_addr_r,
  output logic cache_req_excl_r,
  output logic cache_req_evict_next_r,
  output logic cache_req_no_read_r,
  output logic [TRK_ID_W-1:0] cache_req_id_r,
  input wire logic fill_valid,
  input wire logic [TRK_ID_W-1:0] fill_id,
  input wire logic st_drain,
  input wire logic ret_valid,
  input wire logic [SEQ_W-1:0] ret_seq,
  output logic ld_valid_r,
  output logic ld_fwd_r,
  output logic ld_miss_r,
  output logic ld_hold_r,
  output logic [SEQ_W-1:0] ld_seq_r,
  output logic [DATA_W-1:0] ld_data_r,
  output logic replay_r,
  output logic [SEQ_W-1:0] replay_seq_r,
  output logic align_trap_r,
  output logic fw_dismiss_r,
  output logic mv_valid_r,
  output logic [DATA_W-1:0] mv_data_r
);
  typedef enum logic [2:0] {
    ST_RUN, ST_WAIT_FILL, ST_WAIT_ANY, ST_WAIT_DRAIN, ST_REFETCH, ST_DISMISS
  } st_t;
  typedef struct packed {
    st_t st;
    logic [4:0] cnt;
    logic [TRK_ID_W-1:0] wait_id;
    logic ready;
    logic ld_valid, ld_fwd, ld_miss, ld_hold;
    logic [SEQ_W-1:0] ld_seq;
    logic [DATA_W-1:0] ld_data;
    logic req_valid, req_excl, req_evict, req_no_read;
    logic [ADDR_W-1:0] req_addr;
    logic [TRK_ID_W-1:0] req_id;
    logic replay;
    logic [SEQ_W-1:0] replay_seq;
    logic align_trap, dismiss, mv_valid;
    logic [DATA_W-1:0] mv_data;
    logic [LR_N-1:0] lr_vld;
    logic [LR_N-1:0][ADDR_W-1:ALIGN_LSB] lr_addr;
    logic [LR_N-1:0][SEQ_W-1:0] lr_seq;
    logic [LR_N-1:0][WT_IDX_W-1:0] lr_pc;
    logic [LR_PTR_W-1:0] lr_ptr;
    logic [WT_ENTRIES-1:0][1:0] wt_cnt;
  } core_t;
  core_t r, n;

  logic take, is_pf, is_evict, is_excl, is_hint, misaligned, miss_go, load_wait;
  logic trk_full, trk_idx_hit;
  logic [TRK_ID_W-1:0] trk_free_id, trk_idx_id;
  logic sq_fwd_hit, sq_older, sq_full;
  logic [DATA_W-1:0] sq_fwd_data;
  logic [LR_N-1:0] lr_younger;
  mem_op_t op;

  // decode of the issued operation
  assign op = mem_op_t'(iss_op);
  assign take = iss_valid && r.ready;
  assign is_pf = op inside {OP_PREFETCH, OP_PREFETCH_EVICT_NEXT, OP_PREFETCH_MODIFY,
                            OP_MODIFY_INTENT_PREFETCH_EVICT_NEXT, OP_BLOCK_WRITE_HINT,
                            OP_BLOCK_WRITE_HINT_EVICT_NEXT};
  assign is_evict = op inside {OP_PREFETCH_EVICT_NEXT, OP_MODIFY_INTENT_PREFETCH_EVICT_NEXT,
                               OP_BLOCK_WRITE_HINT_EVICT_NEXT};
  assign is_excl = op inside {OP_PREFETCH_MODIFY, OP_MODIFY_INTENT_PREFETCH_EVICT_NEXT};
  assign is_hint = op inside {OP_BLOCK_WRITE_HINT, OP_BLOCK_WRITE_HINT_EVICT_NEXT};
  assign misaligned = iss_addr[ALIGN_LSB-1:0] != '0;
  assign load_wait = r.wt_cnt[iss_pc_idx] >= WT_TRAP_LIMIT;

  // executed loads that are younger than an issuing store to the same quadword
  genvar g;
  generate
    for (g = 0; g < LR_N; g++) begin : g_lr
      assign lr_younger[g] = r.lr_vld[g] && seq_older(iss_seq, r.lr_seq[g])
                             && r.lr_addr[g] == iss_addr[ADDR_W-1:ALIGN_LSB];
    end
  endgenerate

  miss_address_tracker u_trk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .late_variant(late_variant),
    .alloc(miss_go),
    .alloc_blk(iss_addr[ADDR_W-1:BLK_LSB]),
    .release_en(fill_valid),
    .release_id(fill_id),
    .look_blk(iss_addr[ADDR_W-1:BLK_LSB]),
    .free_id(trk_free_id),
    .full(trk_full),
    .idx_hit(trk_idx_hit),
    .idx_hit_id(trk_idx_id)
  );

  store_queue_forward u_sq (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .push(take && op == OP_STORE),
    .push_addr(iss_addr),
    .push_data(iss_data),
    .push_seq(iss_seq),
    .pop(st_drain),
    .q_addr(iss_addr),
    .q_seq(iss_seq),
    .fwd_hit(sq_fwd_hit),
    .fwd_data(sq_fwd_data),
    .older_pending(sq_older),
    .full(sq_full)
  );

  // operation handling, replay decisions and stall sequencing
  always_comb begin
    logic found;
    logic [SEQ_W-1:0] vseq;
    logic [WT_IDX_W-1:0] vpc;
    logic rec;
    found = 1'b0;
    vseq = '0;
    vpc = '0;
    rec = 1'b0;
    miss_go = 1'b0;
    n = r;
    {n.ld_valid, n.ld_fwd, n.ld_miss, n.ld_hold, n.req_valid} = '0;
    {n.req_excl, n.req_evict, n.req_no_read, n.replay} = '0;
    {n.align_trap, n.dismiss, n.mv_valid} = '0;
    for (int i = 0; i < LR_N; i++) begin
      if (lr_younger[i] && (!found || seq_older(r.lr_seq[i], vseq))) begin
        found = 1'b1;
        vseq = r.lr_seq[i];
        vpc = r.lr_pc[i];
      end
    end
    if (take) begin
      n.ld_seq = iss_seq;
      n.replay_seq = iss_seq;
      if (op == OP_FLOAT_TO_INT_MOVE || op == OP_INT_TO_FLOAT_MOVE) begin
        n.mv_valid = 1'b1;
        n.mv_data = iss_data;
      end else if (op == OP_STORE) begin
        if (sq_full) begin
          n.replay = 1'b1;
          n.st = st_drain ? ST_REFETCH : ST_WAIT_DRAIN; // a drain now already frees a slot
        end else if (found) begin
          n.replay = 1'b1;
          n.replay_seq = vseq;
          n.st = ST_REFETCH;
          if (r.wt_cnt[vpc] != WT_CNT_MAX) begin
            n.wt_cnt[vpc] = r.wt_cnt[vpc] + 2'h1;
          end
        end
      end else if (is_pf && misaligned) begin
        n.align_trap = 1'b1;
      end else if (is_pf && iss_addr_bad) begin
        n.dismiss = 1'b1;
        n.st = ST_DISMISS;
        n.cnt = DISMISS_CYC - 5'h01;
      end else if (op == OP_LOAD && load_wait && sq_older) begin
        n.ld_hold = 1'b1;
      end else if (op == OP_LOAD && sq_fwd_hit) begin
        n.ld_valid = 1'b1;
        n.ld_fwd = 1'b1;
        n.ld_data = sq_fwd_data;
        rec = 1'b1;
      end else if (is_hint) begin
        n.req_valid = 1'b1;
        n.req_no_read = 1'b1;
        n.req_evict = is_evict;
        n.req_addr = {iss_addr[ADDR_W-1:BLK_LSB], {BLK_LSB{1'b0}}};
      end else if (cache_hit && (!is_excl || cache_hit_owned)) begin
        n.ld_valid = op == OP_LOAD;
        n.ld_data = cache_rdata;
        rec = op == OP_LOAD;
      end else if (trk_idx_hit) begin
        n.replay = 1'b1;
        n.st = (fill_valid && fill_id == trk_idx_id) ? ST_REFETCH : ST_WAIT_FILL; // no lost fill
        n.wait_id = trk_idx_id;
      end else if (trk_full) begin
        n.replay = 1'b1;
        n.st = fill_valid ? ST_REFETCH : ST_WAIT_ANY; // a fill now already frees an entry
      end else begin
        miss_go = 1'b1;
        n.req_valid = 1'b1;
        n.req_excl = is_excl;
        n.req_evict = is_evict;
        n.req_id = trk_free_id;
        n.req_addr = {iss_addr[ADDR_W-1:BLK_LSB], {BLK_LSB{1'b0}}};
        n.ld_miss = op == OP_LOAD;
        rec = op == OP_LOAD;
      end
    end
    // retire and replay flush of the watched loads
    for (int i = 0; i < LR_N; i++) begin
      if (ret_valid && !seq_older(ret_seq, r.lr_seq[i])) begin
        n.lr_vld[i] = 1'b0;
      end
      if (n.replay && !seq_older(r.lr_seq[i], n.replay_seq)) begin
        n.lr_vld[i] = 1'b0;
      end
    end
    if (rec) begin
      n.lr_vld[r.lr_ptr] = 1'b1;
      n.lr_addr[r.lr_ptr] = iss_addr[ADDR_W-1:ALIGN_LSB];
      n.lr_seq[r.lr_ptr] = iss_seq;
      n.lr_pc[r.lr_ptr] = iss_pc_idx;
      n.lr_ptr = r.lr_ptr + 1'b1;
    end
    // stall until the trap cause has gone
    case (r.st)
      ST_RUN: begin
      end
      ST_WAIT_FILL: begin
        if (fill_valid && fill_id == r.wait_id) begin
          n.st = ST_RUN;
        end
      end
      ST_WAIT_ANY: begin
        if (fill_valid) begin
          n.st = ST_RUN;
        end
      end
      ST_WAIT_DRAIN: begin
        if (st_drain) begin
          n.st = ST_RUN;
        end
      end
      ST_REFETCH: begin
        n.st = ST_RUN;
      end
      ST_DISMISS: begin
        n.cnt = r.cnt - 5'h01;
        if (r.cnt == '0) begin
          n.st = ST_RUN;
        end
      end
      default: begin
        n.st = ST_RUN;
      end
    endcase
    n.ready = n.st == ST_RUN;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign iss_ready_r = r.ready;
  assign cache_req_valid_r = r.req_valid;
  assign cache_req_addr_r = r.req_addr;
  assign cache_req_excl_r = r.req_excl;
  assign cache_req_evict_next_r = r.req_evict;
  assign cache_req_no_read_r = r.req_no_read;
  assign cache_req_id_r = r.req_id;
  assign {ld_valid_r, ld_fwd_r, ld_miss_r, ld_hold_r} = {r.ld_valid, r.ld_fwd, r.ld_miss, r.ld_hold};
  assign ld_seq_r = r.ld_seq;
  assign ld_data_r = r.ld_data;
  assign replay_r = r.replay;
  assign replay_seq_r = r.replay_seq;
  assign align_trap_r = r.align_trap;
  assign fw_dismiss_r = r.dismiss;
  assign mv_valid_r = r.mv_valid;
  assign mv_data_r = r.mv_data;

  // checks on the control behaviour
  sequence s_pf_ok;
    take && is_pf && !misaligned && !iss_addr_bad;
  endsequence
  sequence s_replay_stall;
    replay_r && !iss_ready_r;
  endsequence
  property p_move_no_mem;
    @(posedge clk_sys) disable iff (sys_rst)
      take && op inside {OP_FLOAT_TO_INT_MOVE, OP_INT_TO_FLOAT_MOVE}
      |=> mv_valid_r && mv_data_r == $past(iss_data) && !cache_req_valid_r;
  endproperty
  a_move_no_mem: assert property (p_move_no_mem) else $error("move went to memory");
  property p_pf_no_result;
    @(posedge clk_sys) disable iff (sys_rst) take && is_pf |=> !ld_valid_r && !ld_miss_r;
  endproperty
  a_pf_no_result: assert property (p_pf_no_result) else $error("prefetch wrote a result");
  property p_hint_no_read;
    @(posedge clk_sys) disable iff (sys_rst)
      s_pf_ok ##0 is_hint |=> cache_req_valid_r && cache_req_no_read_r
      && cache_req_addr_r[BLK_LSB-1:0] == '0;
  endproperty
  a_hint_no_read: assert property (p_hint_no_read) else $error("write hint read memory");
  property p_excl_evict;
    @(posedge clk_sys) disable iff (sys_rst)
      s_pf_ok |=> cache_req_valid_r |-> cache_req_excl_r == $past(is_excl)
      && cache_req_evict_next_r == $past(is_evict);
  endproperty
  a_excl_evict: assert property (p_excl_evict) else $error("request flavour wrong");
  property p_dismiss_len;
    @(posedge clk_sys) disable iff (sys_rst)
      fw_dismiss_r |-> !iss_ready_r[*8] ##[1:21] iss_ready_r;
  endproperty
  a_dismiss_len: assert property (p_dismiss_len) else $error("dismiss penalty wrong");
  property p_align;
    @(posedge clk_sys) disable iff (sys_rst)
      take && is_pf && misaligned |=> align_trap_r && !cache_req_valid_r;
  endproperty
  a_align: assert property (p_align) else $error("misaligned prefetch not trapped");
  property p_replay_stall;
    @(posedge clk_sys) disable iff (sys_rst) replay_r |-> s_replay_stall;
  endproperty
  a_replay_stall: assert property (p_replay_stall) else $error("no stall after replay");
  property p_full_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      take && op == OP_LOAD && trk_full && !trk_idx_hit && !sq_fwd_hit && !cache_hit
      && !(load_wait && sq_older) |=> replay_r && !cache_req_valid_r
      ##1 (!iss_ready_r || $past(fill_valid) || $past(fill_valid, 2));
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("miss taken with tracker full");
  property p_forward;
    @(posedge clk_sys) disable iff (sys_rst)
      take && op == OP_LOAD && sq_fwd_hit && !(load_wait && sq_older)
      |=> ld_valid_r && ld_fwd_r && ld_data_r == $past(sq_fwd_data);
  endproperty
  a_forward: assert property (p_forward) else $error("store data not forwarded");
endmodule
`default_nettype wire

// ### load_store_replay_prefetch_bench.sv
// self-checking bench for the memory-operation replay and prefetch control
`timescale 1ns/1ps
`default_nettype none
module load_store_replay_prefetch_bench import lsrp_pkg::*;;
  logic clk_sys = 1'b0, sys_rst = 1'b1, late_variant = 1'b0, iss_valid = 1'b0;
  logic iss_addr_bad = 1'b0, st_drain = 1'b0, ret_valid = 1'b0, stall = 1'b0;
  logic [3:0] iss_op = 4'h0;
  logic [WT_IDX_W-1:0] iss_pc_idx = 4'h0;
  logic [SEQ_W-1:0] iss_seq = 8'h0, ret_seq = 8'h0, sq = 8'h0, ld_seq_r, replay_seq_r;
  logic [DATA_W-1:0] iss_data = 64'h0, d = 64'h0, cache_rdata, ld_data_r, mv_data_r;
  logic [ADDR_W-1:0] iss_addr = 32'h0, a, cache_req_addr_r;
  logic cache_hit, cache_hit_owned, fill_valid, iss_ready_r, cache_req_valid_r, replay_r;
  logic cache_req_excl_r, cache_req_evict_next_r, cache_req_no_read_r, ld_valid_r, ld_fwd_r;
  logic ld_miss_r, ld_hold_r, align_trap_r, fw_dismiss_r, mv_valid_r;
  logic [TRK_ID_W-1:0] fill_id, cache_req_id_r;
  logic [2:0] w;
  int fail_count = 0, check_count = 0, cyc = 0, n, cap;
  load_store_replay_prefetch u_dut (.*);
  mem_side_model u_mem (.*);
  always #2.5 clk_sys = ~clk_sys;
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // offer one op, held until the edge that takes it; back makes the tag older
  task automatic issue(input logic [3:0] op, input logic [ADDR_W-1:0] ad,
      input logic [3:0] pc, input logic bad, input logic [7:0] back);
    int k;
    k = 0;
    @(posedge clk_sys);
    #1;
    sq = sq + 8'h1;
    iss_valid = 1'b1;
    iss_op = op;
    iss_addr = ad;
    iss_pc_idx = pc;
    iss_addr_bad = bad;
    iss_seq = sq - back;
    iss_data = d;
    while (!iss_ready_r && k < 100) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check("issue taken", k < 100, 1);
    @(posedge clk_sys);
    #1;
    iss_valid = 1'b0;
    iss_addr = ~iss_addr;
  endtask
  task automatic wait_ready(output int k);
    k = 0;
    while (iss_ready_r !== 1'b1 && k < 200) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
  endtask
  // one pulse of store drain together with one retire of everything issued, in the same cycle
  task automatic drain_retire();
    @(posedge clk_sys);
    #1;
    st_drain = 1'b1;
    ret_valid = 1'b1;
    ret_seq = sq;
    @(posedge clk_sys);
    #1;
    st_drain = 1'b0;
    ret_valid = 1'b0;
  endtask
  // expected qualifiers {owned, evict next, no read} of a prefetch flavour
  function automatic logic [2:0] want(input logic [3:0] op);
    return {op == 4'h4 || op == 4'h5, op == 4'h3 || op == 4'h5 || op == 4'h7, op >= 4'h6};
  endfunction
  // cycle ceiling cuts a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h67112d83));
    repeat (10) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    repeat (2) @(posedge clk_sys);
    // register moves in both directions
    for (int op = 8; op <= 9; op++) begin
      d = {$urandom, $urandom};
      issue(op[3:0], 32'h1000_0000, 4'h0, 1'b0, 8'h0);
      check("mv_valid_r", mv_valid_r, 1);
      check("mv_data_r", mv_data_r, d);
    end
    // every prefetch flavour on a miss, then on a writable hit
    for (int op = 2; op <= 7; op++) begin
      a = {4'h3, 28'($urandom)} & ~32'h7;
      w = want(op[3:0]);
      issue(op[3:0], a, 4'h0, 1'b0, 8'h0);
      check("req_valid", cache_req_valid_r, 1);
      check("req_excl", cache_req_excl_r, w[2]);
      check("req_evict", cache_req_evict_next_r, w[1]);
      check("req_no_read", cache_req_no_read_r, w[0]);
      check("req_addr", cache_req_addr_r, a & ~32'h3f);
      check("ld_valid_r", ld_valid_r, 0);
      repeat (8) @(posedge clk_sys);
      issue(op[3:0], {5'h03, a[26:0]}, 4'h0, 1'b0, 8'h0);
      check("hit req_valid", cache_req_valid_r, w[0]);
    end
    // misaligned pointer traps, invalid address is dismissed
    issue(OP_PREFETCH, 32'h3000_0104, 4'h0, 1'b0, 8'h0);
    check("align_trap_r", align_trap_r, 1);
    check("req_valid", cache_req_valid_r, 0);
    issue(OP_PREFETCH, 32'h3000_0200, 4'h0, 1'b1, 8'h0);
    check("fw_dismiss_r", fw_dismiss_r, 1);
    check("align_trap_r", align_trap_r, 0);
    wait_ready(n);
    check("dismiss short", n < DISMISS_LIMIT_CYC && n > 0, 1);
    // queued store data goes to a later load of the quadword
    d = {$urandom, $urandom};
    a = {4'h1, 28'($urandom)} & ~32'h7;
    issue(OP_STORE, a, 4'h1, 1'b0, 8'h0);
    issue(OP_LOAD, a, 4'h1, 1'b0, 8'h0);
    check("ld_fwd_r", ld_fwd_r, 1);
    check("ld_data_r", ld_data_r, d);
    check("ld_seq_r", ld_seq_r, sq);
    drain_retire();
    // a load run ahead of an older store to its address, twice on one load
    for (int k = 0; k < 2; k++) begin
      a = {4'h1, 28'($urandom)} & ~32'h7;
      issue(OP_LOAD, a, 4'h7, 1'b0, 8'h0);
      check("ld_data_r", ld_data_r, {a, ~a});
      issue(OP_STORE, a, 4'h7, 1'b0, 8'h2);
      check("replay_r", replay_r, 1);
      check("replay_seq_r", replay_seq_r, sq - 8'h1);
      check("iss_ready_r", iss_ready_r, 0);
      wait_ready(n);
      drain_retire();
    end
    // the taught load now waits for an older store to drain
    issue(OP_STORE, 32'h1000_0400, 4'h2, 1'b0, 8'h0);
    issue(OP_LOAD, a ^ 32'h1000, 4'h7, 1'b0, 8'h0);
    check("ld_hold_r", ld_hold_r, 1);
    check("ld_valid_r", ld_valid_r, 0);
    drain_retire();
    issue(OP_LOAD, a ^ 32'h1000, 4'h7, 1'b0, 8'h0);
    check("ld_valid_r", ld_valid_r, 1);
    // tracker filled with fills held back; one more miss must replay
    for (int v = 0; v < 2; v++) begin
      late_variant = v[0];
      cap = v ? TRK_LATE : TRK_EARLY;
      stall = 1'b1;
      for (int i = 0; i <= cap; i++) begin
        issue(OP_LOAD, 32'h2000_0000 + (v << 20) + (i << 6), 4'h0, 1'b0, 8'h0);
        check("ld_miss_r", ld_miss_r, i < cap);
        check("replay_r", replay_r, i == cap);
        if (i < cap) check("req_id", cache_req_id_r < cap, 1);
      end
      stall = 1'b0;
      wait_ready(n);
      check("ready after fill", n < 200, 1);
      repeat (80) @(posedge clk_sys);
      drain_retire();
    end
    // two misses to the same cache index, 32KB apart: the second replays until the first fills
    stall = 1'b1;
    issue(OP_LOAD, 32'h2400_0000, 4'h0, 1'b0, 8'h0);
    check("ld_miss_r", ld_miss_r, 1);
    issue(OP_LOAD, 32'h2400_8000, 4'h0, 1'b0, 8'h0);
    check("replay_r", replay_r, 1);
    check("ld_miss_r", ld_miss_r, 0);
    stall = 1'b0;
    wait_ready(n);
    check("ready after fill", n < 200, 1);
    conclude();
  end
endmodule
`default_nettype wire

// ### lsrp_pkg.sv
// shared constants, types and helpers for the load/store replay and prefetch control
`default_nettype none
package lsrp_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int SEQ_W = 8;
  localparam int BLK_LSB = 6;       // 64-byte block
  localparam int IDX_MSB = 14;      // cache index, blocks 32KB apart collide
  localparam int ALIGN_LSB = 3;     // quadword alignment of pointers
  localparam int TRK_MAX = 15;
  localparam logic [4:0] TRK_EARLY = 5'h08;
  localparam logic [4:0] TRK_LATE = 5'h0f;
  localparam int TRK_ID_W = 4;
  localparam int SQ_DEPTH = 32;
  localparam int SQ_PTR_W = 5;
  localparam int LR_N = 4;          // executed, unretired loads watched for order
  localparam int LR_PTR_W = 2;
  localparam int WT_ENTRIES = 16;
  localparam int WT_IDX_W = 4;
  localparam logic [1:0] WT_TRAP_LIMIT = 2'h2;
  localparam logic [1:0] WT_CNT_MAX = 2'h3;
  localparam int DISMISS_LIMIT_CYC = 30;
  localparam logic [4:0] DISMISS_CYC = 5'h14;
  typedef enum logic [3:0] {
    OP_LOAD, OP_STORE, OP_PREFETCH, OP_PREFETCH_EVICT_NEXT, OP_PREFETCH_MODIFY,
    OP_MODIFY_INTENT_PREFETCH_EVICT_NEXT, OP_BLOCK_WRITE_HINT,
    OP_BLOCK_WRITE_HINT_EVICT_NEXT, OP_FLOAT_TO_INT_MOVE, OP_INT_TO_FLOAT_MOVE
  } mem_op_t;
  // a is older than b when a - b wraps negative
  function automatic logic seq_older(input logic [SEQ_W-1:0] a, input logic [SEQ_W-1:0] b);
    logic [SEQ_W-1:0] d;
    d = a - b;
    return d[SEQ_W-1];
  endfunction
endpackage
`default_nettype wire

// ### mem_side_model.sv
// far-side cache and memory model: lookup answers and delayed fills
`timescale 1ns/1ps
`default_nettype none
module mem_side_model import lsrp_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic [ADDR_W-1:0] iss_addr,
  output logic cache_hit,
  output logic cache_hit_owned,
  output logic [DATA_W-1:0] cache_rdata,
  input wire logic cache_req_valid_r,
  input wire logic cache_req_no_read_r,
  input wire logic [TRK_ID_W-1:0] cache_req_id_r,
  output logic fill_valid,
  output logic [TRK_ID_W-1:0] fill_id
);
  logic [TRK_ID_W-1:0] pend[$];
  int gap;
  // region 1 hits, bit 27 marks a block held writable
  assign cache_hit = iss_addr[31:28] == 4'h1;
  assign cache_hit_owned = cache_hit && iss_addr[27];
  assign cache_rdata = {iss_addr, ~iss_addr};
  // misses come back one every four cycles unless stalled
  always @(posedge clk_sys) begin
    fill_valid <= 1'b0;
    fill_id <= ~fill_id; // no stale id between fills
    if (sys_rst) begin
      pend.delete();
      gap <= 0;
      fill_id <= 4'h5;
    end else begin
      if (cache_req_valid_r && !cache_req_no_read_r) pend.push_back(cache_req_id_r);
      gap <= (gap == 0) ? 3 : gap - 1;
      if (gap == 0 && !stall && pend.size() > 0) begin
        fill_valid <= 1'b1;
        fill_id <= pend.pop_front();
      end
    end
  end
endmodule
`default_nettype wire

// ### miss_address_tracker.sv
// outstanding off-chip miss tracker with index conflict lookup
`timescale 1ns/1ps
`default_nettype none
module miss_address_tracker import lsrp_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic late_variant,
  input wire logic alloc,
  input wire logic [ADDR_W-1:BLK_LSB] alloc_blk,
  input wire logic release_en,
  input wire logic [TRK_ID_W-1:0] release_id,
  input wire logic [ADDR_W-1:BLK_LSB] look_blk,
  output logic [TRK_ID_W-1:0] free_id,
  output logic full,
  output logic idx_hit,
  output logic [TRK_ID_W-1:0] idx_hit_id
);
  typedef struct packed {
    logic [TRK_MAX-1:0] vld;
    logic [TRK_MAX-1:0][ADDR_W-1:BLK_LSB] blk;
  } trk_t;
  trk_t r, r_nxt;
  logic [TRK_MAX-1:0] idx_match;

  // per-entry index compare
  genvar g;
  generate
    for (g = 0; g < TRK_MAX; g++) begin : g_cmp
      assign idx_match[g] = r.vld[g] && (r.blk[g][IDX_MSB:BLK_LSB] == look_blk[IDX_MSB:BLK_LSB]);
    end
  endgenerate

  // capacity, free slot, lookup and update
  always_comb begin
    logic [4:0] cnt;
    logic [4:0] cap;
    cnt = '0;
    cap = late_variant ? TRK_LATE : TRK_EARLY;
    free_id = '0;
    idx_hit = 1'b0;
    idx_hit_id = '0;
    for (int i = TRK_MAX - 1; i >= 0; i--) begin
      if (r.vld[i]) begin
        cnt = cnt + 5'h01;
      end else if (5'(i) < cap) begin
        free_id = TRK_ID_W'(i);
      end
      if (idx_match[i]) begin
        idx_hit = 1'b1;
        idx_hit_id = TRK_ID_W'(i);
      end
    end
    full = (cnt >= cap);
    r_nxt = r;
    if (release_en) begin
      r_nxt.vld[release_id] = 1'b0;
    end
    if (alloc && !full) begin
      r_nxt.vld[free_id] = 1'b1;
      r_nxt.blk[free_id] = alloc_blk;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end
endmodule
`default_nettype wire

// ### store_queue_forward.sv
// store queue holding each issued store while a slot is free, with forwarding to later loads
`timescale 1ns/1ps
`default_nettype none
module store_queue_forward import lsrp_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic [ADDR_W-1:0] push_addr,
  input wire logic [DATA_W-1:0] push_data,
  input wire logic [SEQ_W-1:0] push_seq,
  input wire logic pop,
  input wire logic [ADDR_W-1:0] q_addr,
  input wire logic [SEQ_W-1:0] q_seq,
  output logic fwd_hit,
  output logic [DATA_W-1:0] fwd_data,
  output logic older_pending,
  output logic full
);
  typedef struct packed {
    logic [SQ_DEPTH-1:0] vld;
    logic [SQ_DEPTH-1:0][ADDR_W-1:ALIGN_LSB] addr;
    logic [SQ_DEPTH-1:0][DATA_W-1:0] data;
    logic [SQ_DEPTH-1:0][SEQ_W-1:0] seq;
    logic [SQ_PTR_W-1:0] head;
    logic [SQ_PTR_W-1:0] tail;
  } sq_t;
  sq_t r, r_nxt;
  logic [SQ_DEPTH-1:0] older;

  // per-entry age compare against the query
  genvar g;
  generate
    for (g = 0; g < SQ_DEPTH; g++) begin : g_age
      assign older[g] = r.vld[g] && seq_older(r.seq[g], q_seq);
    end
  endgenerate

  // forward from the youngest older store to the same quadword
  always_comb begin
    logic [SEQ_W-1:0] best;
    best = '0;
    fwd_hit = 1'b0;
    fwd_data = '0;
    for (int i = 0; i < SQ_DEPTH; i++) begin
      if (older[i] && r.addr[i] == q_addr[ADDR_W-1:ALIGN_LSB]
          && (!fwd_hit || seq_older(best, r.seq[i]))) begin
        fwd_hit = 1'b1;
        fwd_data = r.data[i];
        best = r.seq[i];
      end
    end
    older_pending = |older;
    full = &r.vld;
    r_nxt = r;
    if (pop && r.vld[r.head]) begin
      r_nxt.vld[r.head] = 1'b0;
      r_nxt.head = r.head + 1'b1;
    end
    if (push && !full) begin
      r_nxt.vld[r.tail] = 1'b1;
      r_nxt.addr[r.tail] = push_addr[ADDR_W-1:ALIGN_LSB];
      r_nxt.data[r.tail] = push_data;
      r_nxt.seq[r.tail] = push_seq;
      r_nxt.tail = r.tail + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end
endmodule
`default_nettype wire
